// [cbi_bus_model.sv]
// Behavioural central arbiter and memory controller facing the processor bus pins.
`timescale 1ns/1ps
module cbi_bus_model
  import cbi_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic stall,
  input wire logic bus_req_n,
  input wire logic xfer_start_n,
  input wire logic xfer_burst_n,
  input wire logic [ADDR_W-1:0] addr_o,
  output logic bus_grant_n,
  output logic data_grant_n,
  output logic addr_ack_n,
  output logic xfer_ack_n,
  output logic [DATA_W-1:0] data_i
);
  logic [ADDR_W-1:0] a;
  int n;
  int nb;
  // Each tenure runs to its end; the pins are sampled at the edge, so they show pre-edge values.
  initial begin
    {bus_grant_n, data_grant_n, addr_ack_n, xfer_ack_n} = 4'hf;
    data_i = '0;
    forever begin
      @(posedge clk);
      if (!srst && !bus_req_n && !stall) begin
        #1 bus_grant_n = 1'b0;
        n = 0;
        while (xfer_start_n && n < 64) begin
          @(posedge clk);
          n++;
        end
        a = addr_o;
        nb = xfer_burst_n ? 1 : BEATS;
        #1 bus_grant_n = 1'b1;
        addr_ack_n = 1'b0;
        n = 0;
        while (!xfer_start_n && n < 64) begin
          @(posedge clk);
          n++;
        end
        #1 addr_ack_n = 1'b1;
        data_grant_n = 1'b0;
        repeat (3) @(posedge clk);
        for (int b = 0; b < nb; b++) begin
          #1 xfer_ack_n = 1'b0;
          data_i = {a, 30'h0, b[1:0]};
          @(posedge clk);
        end
        #1 xfer_ack_n = 1'b1;
        data_grant_n = 1'b1;
        // A released data bus must not keep showing the last beat.
        data_i = ~data_i;
      end
    end
  end
endmodule : cbi_bus_model

// [cbi_bus_top.sv]
// Processor system bus interface: arbitration, transfers, snoop answers and copyback buffers.
`timescale 1ns/1ps
module cbi_bus_top
  import cbi_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [31:0] impl_config_reg_a,
  input wire cbi_mode_t bus_mode,
  input wire logic [RATIO_W-1:0] pll_cfg,
  output logic [31:0] impl_config_reg_b,
  input wire logic instr_xlate_enable,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_fetch,
  input wire logic req_write,
  input wire logic req_burst,
  input wire logic req_le,
  input wire logic req_m,
  input wire logic [3:0] req_size,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic align_err,
  output logic req_done,
  output logic fwd_valid,
  output logic [1:0] fwd_beat,
  output logic [DATA_W-1:0] fwd_data,
  input wire logic cb_wr_valid,
  output logic cb_wr_ready,
  input wire logic [2:0] cb_wr_kind,
  input wire logic [1:0] cb_wr_beat,
  input wire logic [ADDR_W-1:0] cb_wr_addr,
  input wire logic [DATA_W-1:0] cb_wr_data,
  output logic snp_lookup,
  output logic [ADDR_W-1:0] snp_addr,
  input wire logic snp_hit,
  input wire logic snp_modified,
  output logic bus_req_n,
  input wire logic bus_grant_n,
  input wire logic data_grant_n,
  input wire logic addr_ack_n,
  input wire logic xfer_ack_n,
  input wire logic data_retry_n,
  output logic xfer_start_n,
  output logic [2:0] xfer_type,
  output logic xfer_burst_n,
  output logic [3:0] xfer_size,
  output logic global_snoop_req_n,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic ext_start_n,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_i,
  output logic addr_bus_busy_n_o,
  output logic addr_bus_busy_n_oe,
  input wire logic addr_bus_busy_n_i,
  output logic data_bus_busy_n_o,
  output logic data_bus_busy_n_oe,
  input wire logic data_bus_busy_n_i,
  output logic addr_retry_resp_n_o,
  output logic addr_retry_resp_n_oe,
  output logic shared_resp_n_o,
  output logic shared_resp_n_oe
);
  localparam int SW = 9 + ADDR_W + DATA_W;
  cbi_state_t state_q;
  logic [SW-1:0] s1_q, s2_q;
  logic bg, dg, aack, ta, data_retry, abb_ext, dbb_ext, ets;
  logic [ADDR_W-1:0] sa;
  logic [DATA_W-1:0] sd;
  logic pre_dis_q;
  cbi_mode_t mode_q;
  logic [ADDR_W-1:0] cur_addr_q;
  logic [3:0] cur_size_q, split_size_q;
  logic [2:0] cur_tt_q;
  logic cur_write_q, cur_burst_q, cur_gbl_q, cur_cb_q, split_q;
  logic [DATA_W-1:0] cur_wdata_q;
  logic [1:0] beat_q;
  logic pend_q;
  logic [DATA_W-1:0] pend_data_q;
  logic [1:0] pend_beat_q;
  logic [ADDR_W-1:0] cb_addr_q [NBUF];
  logic [2:0] cb_kind_q [NBUF];
  logic [1:0] cb_cnt_q, cb_head_q, cb_tail_q;
  logic cb_pop, cb_push, dg_ok, ta_rd, nodr;
  logic [3:0] span, wspan;
  logic cross_dw, cross_w, take;
  logic snp_q, snp_ans_q, art_q, shd_q, art_pre_q, shd_pre_q, abb_pre_q;
  cbi_cb_if cbp ();

  cbi_cb_mem u_mem (
    .clk(clk),
    .port(cbp)
  );

  // Every pin passes two flops; the first stage feeds only the second.
  always_ff @(posedge clk) begin
    s1_q <= {bus_grant_n, data_grant_n, addr_ack_n, xfer_ack_n, data_retry_n,
             addr_bus_busy_n_i, data_bus_busy_n_i, ext_start_n, 1'b0, addr_i, data_i};
    s2_q <= s1_q;
  end
  assign {bg, dg, aack, ta, data_retry, abb_ext, dbb_ext, ets} = ~s2_q[SW-1 -: 8];
  assign sa = s2_q[DATA_W +: ADDR_W];
  assign sd = s2_q[DATA_W-1:0];

  // The ratio strap is caught by a clock edge during reset, never by the reset itself.
  always_ff @(posedge clk) begin
    if (srst) begin
      impl_config_reg_b <= CFG_B_RST;
      impl_config_reg_b[RATIO_LSB +: RATIO_W] <= pll_cfg;
    end
  end

  // Latched only while idle so a tenure never sees a half-applied change.
  always_ff @(posedge clk) begin
    if (srst) begin
      pre_dis_q <= 1'b0;
      mode_q <= CBI_NORMAL;
    end else if (state_q == S_IDLE) begin
      pre_dis_q <= impl_config_reg_a[CFG_PRE_DIS_BIT];
      mode_q <= bus_mode;
    end
  end
  assign nodr = (mode_q == CBI_NO_DRETRY);

  assign span = {1'b0, req_addr[2:0]} + req_size;
  assign wspan = {2'b00, req_addr[1:0]} + req_size;
  assign cross_dw = !req_burst && (span > DWORD_BYTES);
  assign cross_w = !req_burst && req_le && (wspan > WORD_BYTES);
  assign req_ready = (state_q == S_IDLE) && (cb_cnt_q == CB_CNT_RST) && !split_q;
  assign take = req_valid && req_ready;
  assign cb_pop = (state_q == S_IDLE) && (cb_cnt_q != CB_CNT_RST) && !split_q;
  assign dg_ok = dg && !dbb_ext && (nodr || !data_retry);
  assign ta_rd = ta && !cur_write_q;
  assign align_err = take && cross_dw;

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= S_IDLE;
      beat_q <= 2'h0;
    end else begin
      unique case (state_q)
        S_IDLE: if (cb_pop || split_q || (take && !cross_dw)) begin
          state_q <= S_REQ;
        end
        S_REQ: if (bg && !abb_ext) begin
          state_q <= S_ADDR;
        end
        S_ADDR: if (aack) begin
          state_q <= S_DGNT;
        end
        S_DGNT: if (dg_ok) begin
          state_q <= S_DATA;
          beat_q <= 2'h0;
        end
        S_DATA: if (ta) begin
          if (!cur_burst_q || beat_q == BEAT_LAST) begin
            state_q <= (cur_write_q || nodr) ? S_PRE : S_TAIL;
          end else begin
            beat_q <= beat_q + 2'h1;
          end
        end else if (data_retry && !nodr && pend_q && beat_q != 2'h0) begin
          beat_q <= beat_q - 2'h1;
        end
        S_TAIL: state_q <= data_retry ? S_DATA : S_PRE;
        S_PRE: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_addr_q <= '0;
      cur_size_q <= 4'h0;
      cur_tt_q <= TT_READ;
      cur_write_q <= 1'b0;
      cur_burst_q <= 1'b0;
      cur_gbl_q <= 1'b0;
      cur_cb_q <= 1'b0;
      cur_wdata_q <= '0;
      split_q <= 1'b0;
      split_size_q <= 4'h0;
    end else if (cb_pop) begin
      cur_addr_q <= cb_addr_q[cb_head_q];
      cur_tt_q <= cb_kind_q[cb_head_q];
      cur_write_q <= 1'b1;
      cur_burst_q <= 1'b1;
      cur_gbl_q <= 1'b1;
      cur_cb_q <= 1'b1;
      cur_size_q <= DWORD_BYTES;
    end else if (state_q == S_IDLE && split_q) begin
      split_q <= 1'b0;
      cur_addr_q <= {cur_addr_q[ADDR_W-1:2], 2'b00} + WORD_STEP;
      cur_size_q <= split_size_q;
    end else if (take && !cross_dw) begin
      cur_addr_q <= req_addr;
      cur_tt_q <= req_fetch ? TT_FETCH : (req_write ? TT_WRITE : TT_READ);
      cur_write_q <= req_write && !req_fetch;
      cur_burst_q <= req_burst;
      cur_cb_q <= 1'b0;
      cur_wdata_q <= req_wdata;
      cur_size_q <= cross_w ? (WORD_BYTES - {2'b00, req_addr[1:0]}) : req_size;
      split_q <= cross_w;
      split_size_q <= wspan - WORD_BYTES;
      if (!req_fetch) begin
        cur_gbl_q <= req_m;
      end else if (!impl_config_reg_a[CFG_FETCH_COH_BIT]) begin
        cur_gbl_q <= 1'b0;
      end else begin
        cur_gbl_q <= instr_xlate_enable ? req_m : 1'b1;
      end
    end
  end

  // Read beats are staged a cycle in modes that may see a data retry.
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_q <= 1'b0;
      pend_data_q <= '0;
      pend_beat_q <= 2'h0;
      fwd_valid <= 1'b0;
      fwd_data <= '0;
      fwd_beat <= 2'h0;
    end else begin
      fwd_valid <= 1'b0;
      pend_q <= 1'b0;
      if (state_q == S_DATA && ta_rd && nodr) begin
        fwd_valid <= 1'b1;
        fwd_data <= sd;
        fwd_beat <= beat_q;
      end else if (state_q == S_DATA && ta_rd) begin
        pend_q <= 1'b1;
        pend_data_q <= sd;
        pend_beat_q <= beat_q;
      end
      if (pend_q && !data_retry) begin
        fwd_valid <= 1'b1;
        fwd_data <= pend_data_q;
        fwd_beat <= pend_beat_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      req_done <= 1'b0;
    end else begin
      req_done <= (state_q == S_PRE) && !cur_cb_q && !split_q;
    end
  end

  // Three copyback lines let castouts queue behind each other on the bus.
  assign cb_push = cb_wr_valid && cb_wr_ready && (cb_wr_beat == BEAT_LAST);
  assign cb_wr_ready = (cb_cnt_q != CB_FULL);
  assign cbp.wr_en = cb_wr_valid && cb_wr_ready;
  assign cbp.wr_idx = IDX_W'(cb_tail_q * BEATS + cb_wr_beat);
  assign cbp.wr_data = cb_wr_data;
  assign cbp.rd_idx = IDX_W'(cb_head_q * BEATS + beat_q);

  always_ff @(posedge clk) begin
    if (srst) begin
      cb_cnt_q <= CB_CNT_RST;
      cb_head_q <= 2'h0;
      cb_tail_q <= 2'h0;
    end else begin
      if (cb_push) begin
        cb_addr_q[cb_tail_q] <= cb_wr_addr;
        cb_kind_q[cb_tail_q] <= cb_wr_kind;
        cb_tail_q <= (cb_tail_q == 2'h2) ? 2'h0 : cb_tail_q + 2'h1;
      end
      if (state_q == S_PRE && cur_cb_q) begin
        cb_head_q <= (cb_head_q == 2'h2) ? 2'h0 : cb_head_q + 2'h1;
      end
      cb_cnt_q <= cb_cnt_q + {1'b0, cb_push} - {1'b0, state_q == S_PRE && cur_cb_q};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      data_o <= '0;
    end else if (state_q == S_DGNT || state_q == S_DATA) begin
      data_o <= cur_cb_q ? cbp.rd_data : cur_wdata_q;
    end
  end
  assign data_oe = cur_write_q && (state_q == S_DATA);

  assign bus_req_n = !(state_q == S_REQ);
  assign xfer_start_n = !(state_q == S_ADDR);
  assign addr_oe = (state_q == S_ADDR);
  assign addr_o = cur_addr_q;
  assign xfer_type = cur_tt_q;
  assign xfer_burst_n = !cur_burst_q;
  assign xfer_size = cur_size_q;
  assign global_snoop_req_n = !(cur_gbl_q && state_q == S_ADDR);
  // Busy lines are driven low, driven high one cycle, then released.
  always_ff @(posedge clk) begin
    if (srst) begin
      abb_pre_q <= 1'b0;
    end else begin
      abb_pre_q <= (state_q == S_ADDR) && aack;
    end
  end
  assign addr_bus_busy_n_oe = (state_q == S_ADDR) || abb_pre_q;
  assign addr_bus_busy_n_o = (state_q != S_ADDR);
  assign data_bus_busy_n_oe = (state_q == S_DATA) || (state_q == S_TAIL) || (state_q == S_PRE);
  assign data_bus_busy_n_o = (state_q == S_PRE);

  // Snoop lookups of other masters, answered two cycles later.
  always_ff @(posedge clk) begin
    if (srst) begin
      snp_q <= 1'b0;
      snp_addr <= '0;
      snp_ans_q <= 1'b0;
      art_q <= 1'b0;
      shd_q <= 1'b0;
      art_pre_q <= 1'b0;
      shd_pre_q <= 1'b0;
    end else begin
      snp_q <= ets && (state_q != S_ADDR);
      snp_addr <= sa;
      snp_ans_q <= snp_q;
      art_q <= snp_ans_q && snp_modified;
      shd_q <= snp_ans_q && snp_hit;
      art_pre_q <= art_q && !pre_dis_q;
      shd_pre_q <= shd_q && !pre_dis_q;
    end
  end
  assign snp_lookup = snp_q;
  assign addr_retry_resp_n_o = !art_q;
  assign addr_retry_resp_n_oe = art_q || art_pre_q;
  assign shared_resp_n_o = !shd_q;
  assign shared_resp_n_oe = shd_q || shd_pre_q;

  a_fetch_gbl_off: assert property (@(posedge clk) disable iff (srst)
    take && req_fetch && !cross_dw && !impl_config_reg_a[CFG_FETCH_COH_BIT] |=> !cur_gbl_q)
    else $error("Fetch with coherency off asserted global.");
  a_fetch_gbl_attr: assert property (@(posedge clk) disable iff (srst)
    take && req_fetch && !cross_dw && impl_config_reg_a[CFG_FETCH_COH_BIT] && instr_xlate_enable
    |=> cur_gbl_q == $past(req_m))
    else $error("Fetch global does not follow attribute.");
  a_fetch_gbl_on: assert property (@(posedge clk) disable iff (srst)
    take && req_fetch && !cross_dw && impl_config_reg_a[CFG_FETCH_COH_BIT] && !instr_xlate_enable
    |=> cur_gbl_q)
    else $error("Untranslated fetch missed global.");
  a_retry_precharge: assert property (@(posedge clk) disable iff (srst)
    art_q && !pre_dis_q && !snp_ans_q |=> addr_retry_resp_n_oe && addr_retry_resp_n_o ##1 !art_pre_q || art_q)
    else $error("Retry line precharge missing.");
  a_nodr_forward: assert property (@(posedge clk) disable iff (srst)
    state_q == S_DATA && ta_rd && nodr |=> fwd_valid && fwd_data == $past(sd))
    else $error("No-retry mode did not forward at once.");
  a_grant_ignore_retry: assert property (@(posedge clk) disable iff (srst)
    state_q == S_DGNT && nodr && dg && !dbb_ext |=> state_q == S_DATA)
    else $error("Data retry blocked grant in no-retry mode.");
  a_split_order: assert property (@(posedge clk) disable iff (srst)
    take && cross_w && !cross_dw |=> split_q ##1 (state_q == S_REQ))
    else $error("Word-crossing access not split.");
  a_align_same: assert property (@(posedge clk) disable iff (srst)
    req_valid && req_ready |-> align_err == (!req_burst && span > DWORD_BYTES))
    else $error("Alignment error depends on byte order.");
  a_cb_bound: assert property (@(posedge clk) disable iff (srst)
    cb_cnt_q == CB_FULL && !(state_q == S_PRE && cur_cb_q) |-> !cb_wr_ready ##1 cb_cnt_q == CB_FULL)
    else $error("Copyback buffer overfilled.");
  a_grant_first: assert property (@(posedge clk) disable iff (srst)
    $rose(state_q == S_ADDR) |-> $past(bg))
    else $error("Address driven without grant.");
  a_mode_stable: assert property (@(posedge clk) disable iff (srst)
    state_q != S_IDLE && $past(state_q) != S_IDLE |-> $stable(mode_q) && $stable(pre_dis_q))
    else $error("Mode changed inside a tenure.");
endmodule : cbi_bus_top

// [cbi_bus_top_tb.sv]
// Self-checking bench for the processor system bus interface.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cbi_bus_top_tb
  import cbi_pkg::*;
;
  logic clk, srst, stall, instr_xlate_enable, req_valid, req_ready, req_fetch, req_write, req_burst, req_le, req_m;
  logic align_err, req_done, fwd_valid, cb_wr_valid, cb_wr_ready, snp_lookup, snp_hit, snp_modified, bus_req_n;
  logic bus_grant_n, data_grant_n, addr_ack_n, xfer_ack_n, data_retry_n, xfer_start_n, xfer_burst_n;
  logic global_snoop_req_n, addr_oe, ext_start_n, data_oe, ab_o, ab_oe, db_o, db_oe, rt_o, rt_oe, sh_o, sh_oe;
  logic [31:0] impl_config_reg_a, impl_config_reg_b, a;
  logic [3:0] pll_cfg, req_size, xfer_size;
  logic [ADDR_W-1:0] req_addr, cb_wr_addr, snp_addr, addr_o, addr_i;
  logic [DATA_W-1:0] req_wdata, fwd_data, cb_wr_data, data_o, data_i;
  logic [1:0] fwd_beat, cb_wr_beat;
  logic [2:0] cb_wr_kind, xfer_type;
  logic start_q = 1'b1;
  logic abb_in = 1'b1;
  logic dbb_in = 1'b1;
  cbi_mode_t bus_mode;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int ack_cyc = -1;
  int last_lat = 0;
  int lat [3];
  logic [99:0] qs [4][$];

  cbi_bus_top cbi_bus_top_i (.clk, .srst, .impl_config_reg_a, .bus_mode, .pll_cfg, .impl_config_reg_b,
    .instr_xlate_enable, .req_valid, .req_ready, .req_fetch, .req_write, .req_burst, .req_le, .req_m, .req_size,
    .req_addr, .req_wdata, .align_err, .req_done, .fwd_valid, .fwd_beat, .fwd_data, .cb_wr_valid, .cb_wr_ready,
    .cb_wr_kind, .cb_wr_beat, .cb_wr_addr, .cb_wr_data, .snp_lookup, .snp_addr, .snp_hit, .snp_modified,
    .bus_req_n, .bus_grant_n, .data_grant_n, .addr_ack_n, .xfer_ack_n, .data_retry_n, .xfer_start_n, .xfer_type,
    .xfer_burst_n, .xfer_size, .global_snoop_req_n, .addr_o, .addr_oe, .addr_i, .ext_start_n, .data_o, .data_oe,
    .data_i, .addr_bus_busy_n_o(ab_o), .addr_bus_busy_n_oe(ab_oe), .addr_bus_busy_n_i(abb_in),
    .data_bus_busy_n_o(db_o), .data_bus_busy_n_oe(db_oe), .data_bus_busy_n_i(dbb_in),
    .addr_retry_resp_n_o(rt_o), .addr_retry_resp_n_oe(rt_oe), .shared_resp_n_o(sh_o), .shared_resp_n_oe(sh_oe));

  cbi_bus_model cbi_bus_model_i (.clk, .srst, .stall, .bus_req_n, .xfer_start_n, .xfer_burst_n, .addr_o,
    .bus_grant_n, .data_grant_n, .addr_ack_n, .xfer_ack_n, .data_i);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("Counts: checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic timeout_hit();
    n_mismatch++;
    $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    finish_test();
  endtask : timeout_hit

  function automatic logic [99:0] st(input logic m, input logic [31:0] ad, input logic [2:0] t, input logic g);
    return {m, 63'h0, ad, t, g};
  endfunction : st

  // Waits on one of several completion conditions, sampled where outputs are settled.
  task automatic wait_sig(input int w, input int lim);
    int n;
    logic s;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      s = (w == 0) ? req_ready : (w == 1) ? cb_wr_ready : (w == 2) ? req_done : (rt_oe && !rt_o);
    end while (s !== 1'b1 && n < lim);
    if (s !== 1'b1) timeout_hit();
  endtask : wait_sig

  task automatic issue(input logic f, input logic w, input logic b, input logic le, input logic [31:0] ad);
    @(posedge clk);
    #1 {req_valid, req_fetch, req_write, req_burst, req_le, req_size, req_addr} =
      {1'b1, f, w, b, le, le ? WORD_BYTES : DWORD_BYTES, ad};
    req_wdata = {$urandom, $urandom};
    wait_sig(0, 200);
    @(posedge clk);
    #1 req_valid = 1'b0;
  endtask : issue

  task automatic wait_done();
    wait_sig(2, 400);
    @(posedge clk);
    #1;
  endtask : wait_done

  task automatic cb_beat(input logic [2:0] k, input logic [1:0] b, input logic [31:0] ad);
    @(posedge clk);
    #1 {cb_wr_valid, cb_wr_kind, cb_wr_beat, cb_wr_addr} = {1'b1, k, b, ad};
    cb_wr_data = {$urandom, $urandom};
    wait_sig(1, 200);
    @(posedge clk);
    #1 cb_wr_valid = 1'b0;
  endtask : cb_beat

  task automatic chk_q(input int k, input logic [99:0] got);
    logic [99:0] e;
    e = (qs[k].size() == 0) ? ~got : qs[k].pop_front();
    if (e[99]) e[0] = got[0];
    e[99] = 1'b0;
    `CHK(got, e)
  endtask : chk_q

  // A result with no note waiting counts as a mismatch inside chk_q.
  always @(negedge clk) begin
    cyc++;
    if (!srst) begin
      if (!xfer_start_n && start_q) begin
        chk_q(0, st(1'b0, addr_o, xfer_type, global_snoop_req_n));
        `CHK(bus_grant_n, 1'b0)
        `CHK(abb_in, 1'b1)
        ack_cyc = -1;
      end
      if (!xfer_ack_n && ack_cyc == -1) ack_cyc = cyc;
      if (fwd_valid && ack_cyc >= 0) begin
        last_lat = cyc - ack_cyc;
        ack_cyc = -2;
      end
      if (fwd_valid) chk_q(1, 100'({fwd_beat, fwd_data}));
      if (req_valid && req_ready) chk_q(2, 100'(align_err));
      if (snp_lookup) chk_q(3, 100'(snp_addr));
      if (xfer_start_n && !start_q) `CHK(ab_oe && ab_o, 1'b1)
    end
    start_q = xfer_start_n;
  end

  initial begin
    repeat (60000) @(posedge clk);
    timeout_hit();
  end

  initial begin
    {srst, stall, req_valid, req_fetch, req_write, req_burst, req_le, req_m, cb_wr_valid} = 9'h100;
    {snp_hit, snp_modified, instr_xlate_enable, ext_start_n, data_retry_n} = 5'h3;
    {req_size, req_addr, req_wdata, cb_wr_kind, cb_wr_beat, cb_wr_addr, cb_wr_data, addr_i} = '0;
    impl_config_reg_a = '0;
    bus_mode = CBI_NORMAL;
    pll_cfg = '0;
    void'($urandom(32'h875bc089));
    for (int i = 0; i < 4; i++) begin
      pll_cfg = 4'($urandom);
      @(posedge clk);
      #1 srst = 1'b1;
      repeat (4) @(posedge clk);
      #1 srst = 1'b0;
      @(negedge clk);
      `CHK(impl_config_reg_b, {pll_cfg, 28'h0})
    end
    $display("Test clock ratio report ended");
    for (int i = 0; i < 8; i++) begin
      a = $urandom & 32'hffff_fff8;
      {impl_config_reg_a, instr_xlate_enable, req_m} = {32'(i[2]) << CFG_FETCH_COH_BIT, i[1], i[0]};
      qs[0].push_back(st(1'b0, a, TT_FETCH, !(i[2] && (!i[1] || i[0]))));
      qs[1].push_back(100'({2'h0, a, 32'h0}));
      // A busy bus from another master must hold off the first fetch.
      if (i == 0) begin
        {abb_in, dbb_in} = 2'h0;
        fork
          begin
            repeat (12) @(posedge clk);
            #1 {abb_in, dbb_in} = 2'h3;
          end
        join_none
      end
      qs[2].push_back(100'h0);
      issue(1'b1, 1'b0, 1'b0, 1'b0, a);
      wait_done();
    end
    $display("Test fetch coherency ended");
    {impl_config_reg_a, instr_xlate_enable, req_m} = 34'h1;
    for (int m = 0; m < 3; m++) begin
      bus_mode = cbi_mode_t'(m);
      // Retry held asserted in the no-retry mode must be ignored there.
      data_retry_n = (m != 2);
      a = $urandom & 32'hffff_ffe0;
      qs[0].push_back(st(1'b1, a, TT_READ, 1'b0));
      for (int b = 0; b < BEATS; b++) qs[1].push_back(100'({2'(b), a, 30'h0, 2'(b)}));
      qs[2].push_back(100'h0);
      issue(1'b0, 1'b0, 1'b1, 1'b0, a);
      wait_done();
      lat[m] = last_lat;
    end
    `CHK(lat[1], lat[0])
    `CHK(lat[2] + 1, lat[0])
    {data_retry_n, bus_mode} = {1'b1, CBI_NORMAL};
    $display("Test bus modes ended");
    a = $urandom & 32'hffff_fff8;
    qs[2].push_back(100'h0);
    qs[0].push_back(st(1'b1, a + 32'h2, TT_WRITE, 1'b0));
    qs[0].push_back(st(1'b1, a + WORD_STEP, TT_WRITE, 1'b0));
    issue(1'b0, 1'b1, 1'b0, 1'b1, a + 32'h2);
    wait_done();
    for (int le = 0; le < 2; le++) begin
      qs[2].push_back(100'h1);
      issue(1'b0, 1'b1, 1'b0, le[0], a + 32'h6);
      wait_sig(0, 40);
    end
    $display("Test byte order split ended");
    @(posedge clk);
    #1 stall = 1'b1;
    for (int k = 0; k < NBUF; k++) begin
      a = $urandom & 32'hffff_ffe0;
      qs[0].push_back(st(1'b0, a, 3'(k + 2), 1'b0));
      for (int b = 0; b < BEATS; b++) cb_beat(3'(k + 2), 2'(b), a);
    end
    @(negedge clk);
    `CHK(cb_wr_ready, 1'b0)
    @(posedge clk);
    #1 stall = 1'b0;
    for (int n = 0; n < 600 && qs[0].size() != 0; n++) @(negedge clk);
    if (qs[0].size() != 0) timeout_hit();
    wait_sig(0, 400);
    $display("Test copyback buffers ended");
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      #1 impl_config_reg_a = 32'(p) << CFG_PRE_DIS_BIT;
      {snp_hit, snp_modified, ext_start_n} = {1'($urandom), 2'h2};
      a = $urandom;
      addr_i = a;
      qs[3].push_back(100'(a));
      @(posedge clk);
      #1 ext_start_n = 1'b1;
      addr_i = ~a;
      wait_sig(3, 20);
      `CHK(sh_oe && !sh_o, snp_hit)
      @(negedge clk);
      `CHK(rt_oe, p == 0)
      `CHK(sh_oe, snp_hit && p == 0)
      if (p == 0) `CHK(rt_o, 1'b1)
      repeat (4) @(posedge clk);
    end
    $display("Test snoop response ended");
    for (int k = 0; k < 4; k++) `CHK(qs[k].size(), 0)
    finish_test();
  end
endmodule : cbi_bus_top_tb

// [cbi_cb_if.sv]
// Port group between the bus engine and the copyback buffer memory.
`timescale 1ns/1ps
interface cbi_cb_if;
  import cbi_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0] rd_data;
  modport owner (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : cbi_cb_if

// [cbi_cb_mem.sv]
// Copyback line storage: three lines of four double words, registered read.
`timescale 1ns/1ps
module cbi_cb_mem
  import cbi_pkg::*;
(
  input wire logic clk,
  cbi_cb_if.mem port
);
  logic [DATA_W-1:0] mem_q [NBUF*BEATS];

  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem_q[port.wr_idx] <= port.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    port.rd_data <= mem_q[port.rd_idx];
  end
endmodule : cbi_cb_mem

// [cbi_pkg.sv]
// Constants, field positions and state types for the processor system bus interface.
package cbi_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int NBUF = 3;
  localparam int BEATS = 4;
  localparam int IDX_W = 4;
  localparam int CFG_FETCH_COH_BIT = 23;
  localparam int CFG_PRE_DIS_BIT = 7;
  localparam int RATIO_LSB = 28;
  localparam int RATIO_W = 4;
  localparam logic [31:0] CFG_B_RST = 32'h0000_0000;
  localparam logic [3:0] DWORD_BYTES = 4'h8;
  localparam logic [3:0] WORD_BYTES = 4'h4;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam logic [1:0] CB_CNT_RST = 2'h0;
  localparam logic [1:0] CB_FULL = 2'h3;
  localparam logic [2:0] TT_READ = 3'h0;
  localparam logic [2:0] TT_WRITE = 3'h1;
  localparam logic [2:0] TT_CASTOUT = 3'h2;
  localparam logic [2:0] TT_FLUSH = 3'h3;
  localparam logic [2:0] TT_CLEAN = 3'h4;
  localparam logic [2:0] TT_FETCH = 3'h5;
  typedef enum logic [1:0] {CBI_NORMAL, CBI_FAST_L2, CBI_NO_DRETRY} cbi_mode_t;
  typedef enum {S_IDLE, S_REQ, S_ADDR, S_DGNT, S_DATA, S_TAIL, S_PRE} cbi_state_t;
endpackage : cbi_pkg
